// [inc/dpa_pkg.sv]
// Shared types and constants for the dual pipeline converter back end.
// Assumes one system clock and an external sample clock sampled by it.
package dpa_pkg;

   localparam int CODE_W       = 10;
   localparam int STAGE_CNT    = 9;
   localparam int RAW_W        = 2 * STAGE_CNT;
   // Alignment line depth; output leaves from its last slot
   localparam int LINE_DEPTH   = 6;
   // Sample clock cycles from sample to output word
   localparam int LATENCY_CYC  = 6;
   // Sample clock cycles before output data is valid
   localparam int INIT_CYC     = 20;
   localparam int INIT_CNT_W   = 5;
   localparam logic [INIT_CNT_W-1:0] INIT_LAST = INIT_CNT_W'(INIT_CYC);
   localparam logic [CODE_W-1:0] CODE_FULL = 10'h03ff;
   localparam logic [CODE_W-1:0] CODE_ZERO = 10'h0000;

   // Raw stage decisions, two bits per stage, stage 1 in the low bits
   typedef struct packed {
      logic [RAW_W-1:0] i;
      logic [RAW_W-1:0] q;
   } dpa_raw_t;

   // Final offset binary codes of both channels
   typedef struct packed {
      logic [CODE_W-1:0] i;
      logic [CODE_W-1:0] q;
   } dpa_code_t;

   typedef struct packed {
      logic [LINE_DEPTH-1:0][RAW_W-1:0] i;
      logic [LINE_DEPTH-1:0][RAW_W-1:0] q;
   } dpa_line_t;

   typedef struct packed {
      logic                  clk_meta;
      logic                  clk_sync;
      logic                  clk_prev;
      dpa_raw_t              raw_meta;
      dpa_raw_t              raw_sync;
      logic                  phase_sample;
      logic                  phase_hold;
      dpa_line_t             line;
      dpa_code_t             code;
      logic                  strobe;
      logic [INIT_CNT_W-1:0] init_cnt;
      logic                  valid;
   } dpa_state_t;

   localparam dpa_state_t ST_RESET = '0;

endpackage

// [hdl/dpa_backend.sv]
// Digital back end of two pipelined 10-bit converter channels.
// Holds the phase generator, the alignment line, the output register
// and one small correction module used once per channel.
// Assumes the analog core delivers stage decisions as levels, and the
// sample clock arrives asynchronously, much slower than SYS_CLK.
// Capturing logic takes CODE_OUT while CODE_STROBE is high and
// ignores every word until DATA_VALID rises.
//
// Notes on behaviour
// - Non-overlapping sample and hold phases come from the sample clock.
// - Eight two-bit stages, then a two-bit flash ninth stage.
// - Each stage runs in the phase opposite to its predecessor.
// - Each of the eight two-bit stage words before the flash carries one redundant bit.
// - Delay line aligns all stage bits to stage nine, giving eighteen bits.
// - Correction removes stage errors, one 10-bit word per sample.
// - A sample's word appears after the sixth following sample clock.
// - After latency, one new word appears every sample clock.
// - Output is offset binary, rising with input.
// - All ones at positive full scale, all zeros at negative.
// - Up to twenty clocks pass before data valid; discard earlier words.
`timescale 1ns/1ps

module dpa_backend
   import dpa_pkg::*;
(
   // System
   input  wire logic                   SYS_CLK,
   input  wire logic                   SYS_RST,
   // Sample clock from system logic
   input  wire logic                   SAMPLE_CLK,
   // Stage decisions from the analog core
   input  wire dpa_raw_t               STAGE_BITS,
   // Phases to the analog core
   output logic                        PHASE_SAMPLE,
   output logic                        PHASE_HOLD,
   output logic [STAGE_CNT-1:0]        STAGE_SAMPLING,
   // Output bus
   output dpa_code_t                   CODE_OUT,
   output logic                        CODE_STROBE,
   output logic                        DATA_VALID
);

   dpa_state_t st;
   dpa_state_t next_st;
   logic       clk_rise;
   logic       clk_fall;
   // Corrected words of the oldest line slot
   logic [CODE_W-1:0] corr_i;
   logic [CODE_W-1:0] corr_q;

   // Stage words leave the line through these
   // one corrector a channel
   dpa_correct dpa_correct_i_inst
   (
      .stage_word (st.line.i[LINE_DEPTH-1]),
      .code       (corr_i)
   );

   // identical corrector for the second channel
   dpa_correct dpa_correct_q_inst
   (
      .stage_word (st.line.q[LINE_DEPTH-1]),
      .code       (corr_q)
   );

   // Second and third flops only; first flop feeds nothing else
   assign clk_rise = st.clk_sync & ~st.clk_prev;
   assign clk_fall = ~st.clk_sync & st.clk_prev;

   always_comb
   begin
      next_st = st;

      // Sample clock: two flops, then a third for edges
      next_st.clk_meta = SAMPLE_CLK;
      next_st.clk_sync = st.clk_meta;
      next_st.clk_prev = st.clk_sync;

      // Stage bits cross the same way, ready at each edge
      next_st.raw_meta = STAGE_BITS;
      next_st.raw_sync = st.raw_meta;

      // gap cycle at each edge keeps phases apart
      next_st.phase_sample = st.clk_sync & st.clk_prev;
      next_st.phase_hold = ~st.clk_sync & ~st.clk_prev;
      // Strobe lasts one cycle
      next_st.strobe = 1'b0;

      if (clk_rise)
      begin
         // line advances on the sample clock
         for (int k = LINE_DEPTH - 1; k > 0; k--)
         begin
            next_st.line.i[k] = st.line.i[k-1];
            next_st.line.q[k] = st.line.q[k-1];
         end
         // Fresh slot for the newest sample
         next_st.line.i[0] = '0;
         next_st.line.q[0] = '0;
         for (int s = 0; s < STAGE_CNT; s += 2)
         begin
            next_st.line.i[s/2][2*s +: 2] = st.raw_sync.i[2*s +: 2];
            next_st.line.q[s/2][2*s +: 2] = st.raw_sync.q[2*s +: 2];
         end
      end

      if (clk_fall)
      begin
         // even stages take the other phase
         for (int s = 1; s < STAGE_CNT; s += 2)
         begin
            next_st.line.i[s/2][2*s +: 2] = st.raw_sync.i[2*s +: 2];
            next_st.line.q[s/2][2*s +: 2] = st.raw_sync.q[2*s +: 2];
         end
         // word leaves six clocks after its sample
         next_st.code.i = corr_i;
         next_st.code.q = corr_q;

         next_st.strobe = 1'b1;

         // count init clocks
         // Counter rests at its end value, no wrap
         if (st.init_cnt != INIT_LAST)
         begin
            next_st.init_cnt = st.init_cnt + 1'b1;
         end
      end

      next_st.valid = (st.init_cnt == INIT_LAST);
   end

   // Single register stage holds all state
   always_ff @(posedge SYS_CLK)
   begin
      if (SYS_RST)
      begin
         st <= ST_RESET;
      end
      else
      begin
         st <= next_st;
      end
   end

   // alternate stages sample in opposite phases
   always_comb
   begin
      for (int s = 0; s < STAGE_CNT; s++)
      begin
         STAGE_SAMPLING[s] = (s % 2 == 0) ? st.phase_hold : st.phase_sample;
      end
   end

   // Outputs straight from flops
   assign PHASE_SAMPLE = st.phase_sample;
   assign PHASE_HOLD   = st.phase_hold;
   assign CODE_OUT     = st.code;
   assign CODE_STROBE  = st.strobe;
   assign DATA_VALID   = st.valid;

endmodule

// Overlap-add correction of one channel's eighteen-bit stage word.
// Stage 1 sits in the low bits and weighs most. Each stage's
// redundant bit overlaps the next stage's weight, so a stage that
// decided one step low is made good by the stages after it.
// Largest sum is three times the full weight, beyond full scale.
// Combinational; the caller registers the result.
module dpa_correct
   import dpa_pkg::*;
#(
   parameter int STAGES = STAGE_CNT,
   parameter int OUT_W  = CODE_W
)
(
   // Aligned stage decisions, two bits a stage
   input  wire logic [2*STAGES-1:0] stage_word,
   // Corrected offset binary code
   output logic      [OUT_W-1:0]    code
);

   // Full scale with the spare overflow bit clear
   localparam logic [OUT_W:0] FULL = (OUT_W+1)'(CODE_FULL);

   // One spare bit holds the overflow before saturation
   logic [OUT_W:0] sum;
   // Weighted value of the stage in hand
   logic [OUT_W:0] term;

   always_comb
   begin
      sum  = '0;
      term = '0;

      for (int s = 0; s < STAGES; s++)
      begin
         term = (OUT_W+1)'(stage_word[2*s +: 2]) << (STAGES - 1 - s);
         sum  = sum + term;
      end

      if (sum > FULL)
      begin
         code = FULL[OUT_W-1:0];
      end
      else
      begin
         code = sum[OUT_W-1:0];
      end
   end

endmodule

// [verif/dpa_src.sv]
// Sample clock source and analog core stand-in.
// Assumes the bench picks the stage bits.
`timescale 1ns/1ps
module dpa_src
   import dpa_pkg::*;
(
   // Bench side
   input  wire dpa_raw_t bits,
   // Converter side
   output logic          sclk = 1'b0,
   output dpa_raw_t      stage
);
   always #50 sclk = ~sclk;
   assign stage = bits;
endmodule

// [verif/dpa_backend_chk.sv]
// Timing relations on the converter back end ports.
// Assumes one clock and a synchronous active high reset.
`timescale 1ns/1ps
module dpa_backend_chk
   import dpa_pkg::*;
(
   input wire logic                 SYS_CLK,
   input wire logic                 SYS_RST,
   input wire logic                 SAMPLE_CLK,
   input wire dpa_raw_t             STAGE_BITS,
   input wire logic                 PHASE_SAMPLE,
   input wire logic                 PHASE_HOLD,
   input wire logic [STAGE_CNT-1:0] STAGE_SAMPLING,
   input wire dpa_code_t            CODE_OUT,
   input wire logic                 CODE_STROBE,
   input wire logic                 DATA_VALID
);
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (SYS_RST);
   a_phase_apart: assert property (!(PHASE_SAMPLE && PHASE_HOLD))
      else $error("phases overlap");
   a_phase_gap: assert property ($rose(PHASE_HOLD) |-> !$past(PHASE_SAMPLE))
      else $error("no phase gap");
   a_stage_alt: assert property (STAGE_SAMPLING ==
      {PHASE_HOLD, {4{PHASE_SAMPLE, PHASE_HOLD}}}) else $error("stage phase");
   a_hold_follows: assert property (CODE_STROBE |-> ##[0:2] PHASE_HOLD)
      else $error("hold phase late");
   a_strobe_gap: assert property (CODE_STROBE |=> !CODE_STROBE[*6])
      else $error("strobe too often");
   a_code_hold: assert property (!CODE_STROBE |-> $stable(CODE_OUT))
      else $error("code moved");
   a_valid_late: assert property ($fell(SYS_RST) |-> !DATA_VALID[*8])
      else $error("valid too soon");
   a_valid_stays: assert property (DATA_VALID |=> DATA_VALID)
      else $error("valid dropped");
   cover property (CODE_STROBE && DATA_VALID);
   cover property ($rose(DATA_VALID));
   cover property ($rose(PHASE_HOLD));
endmodule
bind dpa_backend dpa_backend_chk dpa_backend_chk_inst (.*);

// [verif/tb_top.sv]
// Bench for the converter back end.
// Assumes the bound checker and the sample source model.
`timescale 1ns/1ps
module tb_top import dpa_pkg::*;;
   logic      SYS_CLK = 0;
   logic      SYS_RST = 1;
   logic      sclk;
   logic      stb;
   logic      vld;
   dpa_raw_t  bits = '0;
   dpa_raw_t  stage;
   dpa_code_t code;
   int        checked = 0;
   int        miscompares = 0;
   int        cyc = 0;
   always #5 SYS_CLK = ~SYS_CLK;
   dpa_src dpa_src_inst (.bits(bits), .sclk(sclk), .stage(stage));
   dpa_backend dpa_backend_inst (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST),
      .SAMPLE_CLK(sclk), .STAGE_BITS(stage), .PHASE_SAMPLE(), .PHASE_HOLD(),
      .STAGE_SAMPLING(), .CODE_OUT(code), .CODE_STROBE(stb), .DATA_VALID(vld));
   task automatic check(string nm, logic [9:0] seen, logic [9:0] exp);
      checked++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("[ERR] %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic strobe(int n);
      repeat (n)
      begin
         @(negedge SYS_CLK);
         while (stb !== 1'b1) @(negedge SYS_CLK);
      end
   endtask
   function automatic logic [9:0] fold(logic [17:0] b);
      int acc = 0;
      for (int s = 0; s < 9; s++) acc += b[2*s+:2] << (8 - s);
      return (acc > 1023) ? 10'h03ff : acc[9:0];
   endfunction
   task automatic t_valid;
      SYS_RST = 1;
      repeat (2) @(negedge SYS_CLK);
      SYS_RST = 0;
      strobe(19);
      check("valid early", {9'h0, vld}, 10'h0000);
      strobe(1);
      repeat (2) @(negedge SYS_CLK);
      check("valid", {9'h0, vld}, 10'h0001);
   endtask
   task automatic t_codes;
      logic [17:0] w [5] = '{18'h0_0000, 18'h0_0002, 18'h3_ffff,
                             18'h1_5555, 18'h0_0009};
      for (int k = 0; k < 5; k++)
      begin
         bits = {w[k], w[(k+1)%5]};
         strobe(8);
         check("code i", code.i, fold(w[k]));
         check("code q", code.q, fold(w[(k+1)%5]));
      end
   endtask
   task automatic t_latency;
      bits = '0;
      strobe(8);
      bits = {18'h0_0002, 18'h0_0002};
      strobe(5);
      check("lat early", code.i, 10'h0000);
      strobe(1);
      check("lat due", code.q, 10'h0200);
   endtask
   task results;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   always @(posedge SYS_CLK)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         miscompares++;
         results();
      end
   end
   initial
   begin
      t_valid();
      t_codes();
      t_latency();
      t_valid();
      results();
   end
endmodule
